// ===== flash_cmd_decoder.sv
// Purpose: instruction front end of a small serial flash: decode, latch, data-out
// Assumes: host serial clock at most an eighth of clk_in, sampled through two flops
// Notes: array and status back end sit on the same clock behind req_out
module flash_cmd_decoder #(
  parameter logic [7:0] MAKER_ID = 8'h5A,   // arbitrary value
  parameter logic [15:0] PART_ID = 16'hA5C3, // arbitrary value
  parameter logic [7:0] SIG_ID = 8'h3C      // arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sel_n_in,
  input wire logic sck_in,
  input wire logic serial_in_pin_in,
  output logic serial_in_pin_out,
  output logic serial_in_pin_oe_n_out,
  input wire logic so_in,
  output logic so_out,
  output logic so_oe_n_out,
  input wire logic busy_in,
  input wire logic [7:0] stat1_in,
  input wire logic [7:0] stat2_in,
  input wire logic [7:0] array_data_in,
  output logic [23:0] array_addr_out,
  output flash_cmd_pkg::req_s req_out,
  output logic req_valid_out,
  input wire logic req_ready_in,
  output logic write_enable_latch_out,
  output logic powered_down_out
);
  import flash_cmd_pkg::*;

  pins_s pin_q1_r, pin_q2_r;
  logic sck_d_r, sel_d_r;
  phase_e ph_r, opc_ph;
  logic [7:0] opc_r, in_sr_r, out_sr_r, in_word, src_byte, stat1;
  logic [3:0] in_bits_r, out_bits_r, in_bits_nxt;
  logic [2:0] edge_cnt_r, cnt_r, addr_need, dummy_need;
  logic [8:0] prog_cnt_r;
  logic [23:0] addr_r;
  logic [1:0] id_idx_r;
  logic wel_r, pd_r, extra_r, sel_s, rise, fall, desel, dual_in, dual_out, byte_done, exec_ok, load;
  logic src_msb, src_b6, wr_cmd;
  phase_e addr_next, dummy_next;
  req_s pend_r, head_r, tail_r;
  logic pend_v_r, head_v_r, tail_v_r, push, pop, take;
  req_s push_d;

  // pins cross from the host domain: second flop only feeds logic
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_q1_r <= '{sel_n: 1'b1, sck: 1'b0, si: 1'b0, so: 1'b0};
      pin_q2_r <= '{sel_n: 1'b1, sck: 1'b0, si: 1'b0, so: 1'b0};
      sck_d_r <= 1'b0;
      sel_d_r <= 1'b1;
    end else begin
      pin_q1_r <= '{sel_n: sel_n_in, sck: sck_in, si: serial_in_pin_in, so: so_in};
      pin_q2_r <= pin_q1_r;
      sck_d_r <= pin_q2_r.sck;
      sel_d_r <= pin_q2_r.sel_n;
    end
  end

  assign sel_s = pin_q2_r.sel_n;
  assign rise = pin_q2_r.sck && !sck_d_r && !sel_s;
  assign fall = !pin_q2_r.sck && sck_d_r && !sel_s;
  assign desel = sel_s && !sel_d_r;
  assign dual_in = (opc_r == OPC_DUAL_IO) && (ph_r == PH_ADDR || ph_r == PH_DUMMY);
  assign dual_out = (opc_r == OPC_DUAL_IO || opc_r == OPC_DUAL_OUT) && ph_r == PH_OUT;
  // odd address bits on the output pin, even on the input pin
  assign in_word = dual_in ? {in_sr_r[5:0], pin_q2_r.so, pin_q2_r.si} : {in_sr_r[6:0], pin_q2_r.si};
  assign in_bits_nxt = in_bits_r + (dual_in ? 4'h2 : 4'h1);
  assign byte_done = rise && in_bits_nxt == BYTE_BITS &&
    (ph_r == PH_OPC || ph_r == PH_ADDR || ph_r == PH_DUMMY || ph_r == PH_DATAIN);
  assign wr_cmd = opc_r == OPC_STAT_WR || opc_r == OPC_SECTOR || opc_r == OPC_BLOCK_A ||
    opc_r == OPC_BLOCK_B || opc_r == OPC_CHIP_A || opc_r == OPC_CHIP_B;
  // byte boundary and no stray clocks past the command
  assign exec_ok = desel && edge_cnt_r == 3'h0 && !extra_r &&
    (ph_r == PH_TAIL || (ph_r == PH_DATAIN && opc_r == OPC_PROG && prog_cnt_r != 9'h0));

  // opcode decode with busy, power-down and latch gating
  always_comb begin
    opc_ph = PH_IGNORE;
    if (pd_r && in_word != OPC_WAKE) opc_ph = PH_IGNORE;
    else if (busy_in && in_word != OPC_STAT_RD1 && in_word != OPC_STAT_RD2) opc_ph = PH_IGNORE;
    else begin
      case (in_word)
        OPC_LATCH_SET, OPC_LATCH_CLR, OPC_PDOWN: opc_ph = PH_TAIL;
        OPC_CHIP_A, OPC_CHIP_B: opc_ph = wel_r ? PH_TAIL : PH_IGNORE;
        OPC_STAT_WR: opc_ph = wel_r ? PH_DATAIN : PH_IGNORE;
        OPC_PROG, OPC_SECTOR, OPC_BLOCK_A, OPC_BLOCK_B: opc_ph = wel_r ? PH_ADDR : PH_IGNORE;
        OPC_READ, OPC_FAST, OPC_DUAL_OUT, OPC_DUAL_IO: opc_ph = PH_ADDR;
        OPC_STAT_RD1, OPC_STAT_RD2, OPC_IDENT: opc_ph = PH_OUT;
        OPC_MAKER, OPC_WAKE: opc_ph = PH_DUMMY;
        default: opc_ph = PH_IGNORE;
      endcase
    end
  end

  always_comb begin
    addr_need = (opc_r == OPC_MAKER) ? N_MAKER_ADDR : N_ADDR;
    dummy_need = (opc_r == OPC_MAKER) ? N_MAKER_DUMMY : ((opc_r == OPC_WAKE) ? N_WAKE_DUMMY : N_FAST_DUMMY);
    dummy_next = (opc_r == OPC_MAKER) ? PH_ADDR : PH_OUT;
    if (opc_r == OPC_PROG) addr_next = PH_DATAIN;
    else if (opc_r == OPC_READ || opc_r == OPC_MAKER) addr_next = PH_OUT;
    else if (opc_r == OPC_SECTOR || opc_r == OPC_BLOCK_A || opc_r == OPC_BLOCK_B) addr_next = PH_TAIL;
    else addr_next = PH_DUMMY;
  end

  // phase sequencing: one phase per transaction step
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ph_r <= PH_IDLE;
      cnt_r <= 3'h0;
      opc_r <= 8'h00;
    end else if (sel_s) begin
      ph_r <= PH_IDLE;
      cnt_r <= 3'h0;
    end else if (ph_r == PH_IDLE) ph_r <= PH_OPC;
    else if (byte_done) begin
      unique case (ph_r)
        PH_OPC: begin
          opc_r <= in_word;
          ph_r <= opc_ph;
          cnt_r <= 3'h0;
        end
        PH_ADDR: begin
          if (cnt_r + 3'h1 == addr_need) begin
            ph_r <= addr_next;
            cnt_r <= 3'h0;
          end else cnt_r <= cnt_r + 3'h1;
        end
        PH_DUMMY: begin
          if (cnt_r + 3'h1 == dummy_need) begin
            ph_r <= dummy_next;
            cnt_r <= 3'h0;
          end else cnt_r <= cnt_r + 3'h1;
        end
        PH_DATAIN: if (opc_r == OPC_STAT_WR) ph_r <= PH_TAIL;
        PH_IDLE, PH_TAIL, PH_OUT, PH_IGNORE: ;
      endcase
    end
  end

  // input shifter and clock count since select
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_sr_r <= 8'h00;
      in_bits_r <= 4'h0;
      edge_cnt_r <= 3'h0;
      extra_r <= 1'b0;
    end else if (sel_s) begin
      in_bits_r <= 4'h0;
      edge_cnt_r <= 3'h0;
      extra_r <= 1'b0;
    end else if (rise) begin
      edge_cnt_r <= edge_cnt_r + 3'h1;
      if (ph_r == PH_TAIL) extra_r <= 1'b1;
      if (ph_r == PH_DATAIN && opc_r == OPC_PROG && byte_done && prog_cnt_r == PAGE_BYTES) extra_r <= 1'b1;
      in_sr_r <= in_word;
      in_bits_r <= byte_done ? 4'h0 : in_bits_nxt;
    end
  end

  // write enable latch and deep power-down
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wel_r <= 1'b0;
      pd_r <= 1'b0;
    end else begin
      if (exec_ok && opc_r == OPC_LATCH_SET) wel_r <= 1'b1;
      if (exec_ok && (opc_r == OPC_LATCH_CLR || opc_r == OPC_PROG || wr_cmd)) wel_r <= 1'b0;
      if (exec_ok && opc_r == OPC_PDOWN) pd_r <= 1'b1;
      if (byte_done && ph_r == PH_OPC && in_word == OPC_WAKE) pd_r <= 1'b0;
    end
  end

  // status image: live in-progress and latch bits
  always_comb begin
    stat1 = stat1_in;
    stat1[STAT_BUSY_BIT] = busy_in;
    stat1[STAT_LATCH_BIT] = wel_r;
    case (opc_r)
      OPC_STAT_RD1: src_byte = stat1;
      OPC_STAT_RD2: src_byte = stat2_in;
      OPC_IDENT: src_byte = (id_idx_r == 2'h0) ? MAKER_ID : ((id_idx_r == 2'h1) ? PART_ID[15:8] : PART_ID[7:0]);
      OPC_MAKER: src_byte = (id_idx_r[0] ^ addr_r[0]) ? PART_ID[7:0] : MAKER_ID;
      OPC_WAKE: src_byte = SIG_ID;
      default: src_byte = array_data_in;
    endcase
  end
  assign src_msb = src_byte[7];
  assign src_b6 = src_byte[6];
  assign load = fall && ph_r == PH_OUT && out_bits_r == 4'h0;

  // address capture, post-increment as each output byte loads, except under 90h
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_r <= 24'h000000;
      array_addr_out <= 24'h000000;
      id_idx_r <= 2'h0;
    end else begin
      array_addr_out <= addr_r;
      if (sel_s) id_idx_r <= 2'h0;
      else if (byte_done && ph_r == PH_ADDR) addr_r <= {addr_r[15:0], in_word};
      else if (load) begin
        // 90h keeps its address: bit 0 picks which id byte leads
        if (opc_r != OPC_MAKER) addr_r <= addr_r + 24'h000001;
        id_idx_r <= (opc_r == OPC_IDENT && id_idx_r == IDENT_LAST) ? 2'h0 : id_idx_r + 2'h1;
      end
    end
  end

  // output shifter: falling edges, single or dual line
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_sr_r <= 8'h00;
      out_bits_r <= 4'h0;
      so_out <= 1'b0;
      so_oe_n_out <= 1'b1;
      serial_in_pin_out <= 1'b0;
      serial_in_pin_oe_n_out <= 1'b1;
    end else if (sel_s) begin
      out_bits_r <= 4'h0;
      so_oe_n_out <= 1'b1;
      serial_in_pin_oe_n_out <= 1'b1;
    end else if (fall && ph_r == PH_OUT) begin
      so_oe_n_out <= 1'b0;
      if (dual_out) begin
        serial_in_pin_oe_n_out <= 1'b0;
        so_out <= load ? src_byte[7] : out_sr_r[7];
        serial_in_pin_out <= load ? src_byte[6] : out_sr_r[6];
        out_sr_r <= load ? {src_byte[5:0], 2'b00} : {out_sr_r[5:0], 2'b00};
        out_bits_r <= (load ? BYTE_BITS : out_bits_r) - 4'h2;
      end else begin
        so_out <= load ? src_byte[7] : out_sr_r[7];
        out_sr_r <= load ? {src_byte[6:0], 1'b0} : {out_sr_r[6:0], 1'b0};
        out_bits_r <= (load ? BYTE_BITS : out_bits_r) - 4'h1;
      end
    end
  end

  // requests to the array back end
  always_comb begin
    push = 1'b0;
    push_d = '{kind: REQ_PROG_BYTE, addr: addr_r, data: in_word};
    if (byte_done && ph_r == PH_DATAIN && opc_r == OPC_PROG && prog_cnt_r != PAGE_BYTES) push = 1'b1;
    else if (desel && ph_r == PH_DATAIN && opc_r == OPC_PROG) begin
      push = 1'b1;
      push_d.kind = exec_ok ? REQ_PROG_GO : REQ_PROG_DROP;
    end else if (exec_ok && wr_cmd) begin
      push = 1'b1;
      push_d.data = in_sr_r;
      if (opc_r == OPC_STAT_WR) push_d.kind = REQ_STAT_WR;
      else if (opc_r == OPC_SECTOR) push_d.kind = REQ_SECTOR;
      else if (opc_r == OPC_BLOCK_A || opc_r == OPC_BLOCK_B) push_d.kind = REQ_BLOCK;
      else push_d.kind = REQ_CHIP;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) prog_cnt_r <= 9'h000;
    else if (sel_s) prog_cnt_r <= 9'h000;
    else if (push && push_d.kind == REQ_PROG_BYTE) prog_cnt_r <= prog_cnt_r + 9'h001;
  end

  // pending stage plus two-entry buffer; back end may stall up to two byte times
  assign pop = head_v_r && req_ready_in;
  assign take = pend_v_r && !tail_v_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_v_r <= 1'b0;
      head_v_r <= 1'b0;
      tail_v_r <= 1'b0;
      pend_r <= '0;
      head_r <= '0;
      tail_r <= '0;
    end else begin
      if (push) begin
        pend_r <= push_d;
        pend_v_r <= 1'b1;
      end else if (take) pend_v_r <= 1'b0;
      if (pop) begin
        if (tail_v_r) begin
          head_r <= tail_r;
          tail_v_r <= 1'b0;
        end else head_v_r <= 1'b0;
      end
      if (take) begin
        if (!head_v_r || (pop && !tail_v_r)) begin
          head_r <= pend_r;
          head_v_r <= 1'b1;
        end else begin
          tail_r <= pend_r;
          tail_v_r <= 1'b1;
        end
      end
    end
  end
  assign req_out = head_r;
  assign req_valid_out = head_v_r;
  assign write_enable_latch_out = wel_r;
  assign powered_down_out = pd_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence opc_read_s;
    byte_done && ph_r == PH_OPC && in_word == OPC_READ && !pd_r && !busy_in;
  endsequence
  sequence opc_busy_s;
    byte_done && ph_r == PH_OPC && busy_in && in_word != OPC_STAT_RD1 && in_word != OPC_STAT_RD2;
  endsequence
  latch_set_a: assert property (exec_ok && opc_r == OPC_LATCH_SET |=> wel_r)
    else $error("latch not set");
  latch_clear_a: assert property (exec_ok && opc_r == OPC_LATCH_CLR |=> !wel_r && !write_enable_latch_out ##1 !write_enable_latch_out)
    else $error("latch not cleared");
  boundary_reject_a: assert property (desel && edge_cnt_r != 3'h0 |=> $stable(wel_r) && $stable(pd_r))
    else $error("misaligned command executed");
  busy_ignore_a: assert property (opc_busy_s |=> ph_r == PH_IGNORE)
    else $error("command taken while busy");
  pd_ignore_a: assert property (byte_done && ph_r == PH_OPC && pd_r && in_word != OPC_WAKE |=> ph_r == PH_IGNORE && pd_r)
    else $error("command taken in power-down");
  no_latch_a: assert property (byte_done && ph_r == PH_OPC && !wel_r && in_word == OPC_PROG |=> ph_r == PH_IGNORE)
    else $error("program taken without latch");
  read_addr_a: assert property (opc_read_s |=> ph_r == PH_ADDR && cnt_r == 3'h0)
    else $error("read did not enter address phase");
  msb_first_a: assert property (load && !dual_out |=> so_out == $past(src_msb) && !so_oe_n_out)
    else $error("first output bit not msb");
  dual_split_a: assert property (load && dual_out |=> so_out == $past(src_msb) && serial_in_pin_out == $past(src_b6))
    else $error("dual output bit split wrong");
  wake_release_a: assert property (byte_done && ph_r == PH_OPC && in_word == OPC_WAKE |=> !powered_down_out)
    else $error("wake did not release power-down");
endmodule

// ===== flash_cmd_pkg.sv
// Purpose: shared constants and types of the serial flash instruction decoder
// Assumes: one system clock, serial pins sampled through two flops
// Notes: opcodes are single bytes, shifted most significant bit first
package flash_cmd_pkg;
  localparam logic [7:0] OPC_LATCH_SET = 8'h06;
  localparam logic [7:0] OPC_LATCH_CLR = 8'h04;
  localparam logic [7:0] OPC_STAT_RD1 = 8'h05;
  localparam logic [7:0] OPC_STAT_RD2 = 8'h35;
  localparam logic [7:0] OPC_STAT_WR = 8'h01;
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_FAST = 8'h0B;
  localparam logic [7:0] OPC_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OPC_DUAL_IO = 8'hBB;
  localparam logic [7:0] OPC_PROG = 8'h02;
  localparam logic [7:0] OPC_SECTOR = 8'h20;
  localparam logic [7:0] OPC_BLOCK_A = 8'hD8;
  localparam logic [7:0] OPC_BLOCK_B = 8'h52;
  localparam logic [7:0] OPC_CHIP_A = 8'hC7;
  localparam logic [7:0] OPC_CHIP_B = 8'h60;
  localparam logic [7:0] OPC_PDOWN = 8'hB9;
  localparam logic [7:0] OPC_IDENT = 8'h9F;
  localparam logic [7:0] OPC_MAKER = 8'h90;
  localparam logic [7:0] OPC_WAKE = 8'hAB;
  localparam logic [2:0] N_ADDR = 3'h3;
  localparam logic [2:0] N_MAKER_ADDR = 3'h1;
  localparam logic [2:0] N_FAST_DUMMY = 3'h1;
  localparam logic [2:0] N_MAKER_DUMMY = 3'h2;
  localparam logic [2:0] N_WAKE_DUMMY = 3'h3;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] IDENT_LAST = 2'h2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LATCH_BIT = 1;
  typedef enum {PH_IDLE, PH_OPC, PH_ADDR, PH_DUMMY, PH_DATAIN, PH_TAIL, PH_OUT, PH_IGNORE} phase_e;
  typedef enum logic [2:0] {REQ_PROG_BYTE, REQ_PROG_GO, REQ_PROG_DROP, REQ_SECTOR, REQ_BLOCK, REQ_CHIP,
    REQ_STAT_WR} req_kind_e;
  typedef struct packed {
    req_kind_e kind;
    logic [23:0] addr;
    logic [7:0] data;
  } req_s;
  typedef struct packed {
    logic sel_n;
    logic sck;
    logic si;
    logic so;
  } pins_s;
endpackage

// ===== host_bfm.sv
// Purpose: host controller model driving select, serial clock and data lines
// Assumes: clock idles low; high phase lasts five system clocks, low phase six
// Notes: the output line is toggled on every single-line bit the host shifts, so stale values never pass
module host_bfm (
  input wire logic clk_in,
  input wire logic so_line_in,
  input wire logic si_line_in,
  output logic sel_n_out,
  output logic sck_out,
  output logic si_drv_out,
  output logic so_drv_out
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 5; // margin over the four-clock minimum phase
  initial begin
    sel_n_out = 1'b1;
    sck_out = 1'b0; // clock stands still outside frames
    si_drv_out = 1'b0;
    so_drv_out = 1'b1;
  end
  task automatic begin_frame();
    @(negedge clk_in);
    sel_n_out = 1'b0;
    repeat (HALF) @(negedge clk_in);
  endtask
  // dual puts odd bits on the output line and even bits on the input line
  task automatic shift(input logic [7:0] b, input int n, input bit dual, output logic [7:0] r);
    int k;
    r = 8'h00;
    for (k = 0; k < n; k++) begin
      @(negedge clk_in);
      so_drv_out = dual ? b[7 - 2 * k] : ~so_drv_out;
      si_drv_out = dual ? b[6 - 2 * k] : b[7 - k];
      repeat (HALF) @(negedge clk_in);
      if (dual) begin
        r[7 - 2 * k] = so_line_in;
        r[6 - 2 * k] = si_line_in;
      end else begin
        r[7 - k] = so_line_in;
      end
      sck_out = 1'b1;
      repeat (HALF) @(negedge clk_in);
      sck_out = 1'b0;
    end
  endtask
  // caller picks the clock count, so a ragged end is a deliberate test
  task automatic end_frame();
    repeat (HALF) @(negedge clk_in);
    sel_n_out = 1'b1;
    repeat (12) @(negedge clk_in);
  endtask
endmodule

// ===== tb.sv
// Purpose: self-checking bench of the serial flash instruction decoder
// Assumes: back end modelled here; host model drives the serial pins
// Notes: ordinary reads run from a row table, write types by hand
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import flash_cmd_pkg::*;
  localparam logic [7:0] MAKER = 8'h6E; // arbitrary value
  localparam logic [15:0] PART = 16'h1B2D; // arbitrary value
  localparam logic [7:0] SIG = 8'h47; // arbitrary value
  typedef struct packed {
    logic [7:0] opc;
    logic [2:0] npre;
    logic [31:0] pre;
    logic [1:0] mode;
    logic [1:0] nout;
    logic [23:0] expo;
  } row_s;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sel_n, sck, host_si, host_so, si_line, so_line;
  logic dev_si, dev_si_oe_n, dev_so, dev_so_oe_n;
  logic busy_in = 1'b0;
  logic [7:0] stat1_in = 8'hA0;
  logic [7:0] stat2_in = 8'h4C;
  logic [7:0] array_data_in = 8'h00;
  logic [23:0] array_addr;
  req_s req;
  logic req_valid;
  logic req_ready_in = 1'b1;
  logic write_enable_latch, pd, oe_at_end;
  req_s reqs[$];
  row_s rows[10];
  int failures = 0;
  int samples_checked = 0;

  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h96;
  endfunction
  function automatic row_s mk(input logic [7:0] o, input int np, input logic [31:0] p, input int m,
                              input int no, input logic [23:0] e);
    return '{o, 3'(np), p, 2'(m), 2'(no), e};
  endfunction

  always #25 clk_in = ~clk_in;
  // wire level: device wins only while its enable is low
  assign si_line = dev_si_oe_n ? host_si : dev_si;
  assign so_line = dev_so_oe_n ? host_so : dev_so;
  always @(negedge clk_in) array_data_in <= pat(array_addr);
  always @(posedge clk_in) if (req_valid && req_ready_in) reqs.push_back(req);

  host_bfm host_bfm_i (.clk_in(clk_in), .so_line_in(so_line), .si_line_in(si_line), .sel_n_out(sel_n),
    .sck_out(sck), .si_drv_out(host_si), .so_drv_out(host_so));
  flash_cmd_decoder #(.MAKER_ID(MAKER), .PART_ID(PART), .SIG_ID(SIG)) flash_cmd_decoder_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .sel_n_in(sel_n), .sck_in(sck), .serial_in_pin_in(si_line),
    .serial_in_pin_out(dev_si), .serial_in_pin_oe_n_out(dev_si_oe_n), .so_in(so_line), .so_out(dev_so),
    .so_oe_n_out(dev_so_oe_n), .busy_in(busy_in), .stat1_in(stat1_in), .stat2_in(stat2_in),
    .array_data_in(array_data_in), .array_addr_out(array_addr), .req_out(req), .req_valid_out(req_valid),
    .req_ready_in(req_ready_in), .write_enable_latch_out(write_enable_latch), .powered_down_out(pd));

  task automatic check(input logic [34:0] seen, input logic [34:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, expv);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic run_row(input row_s r);
    logic [7:0] rx;
    int i;
    host_bfm_i.begin_frame();
    host_bfm_i.shift(r.opc, 8, 1'b0, rx);
    for (i = int'(r.npre) - 1; i >= 0; i--) host_bfm_i.shift(r.pre[8 * i +: 8], (r.mode == 2) ? 4 : 8, r.mode == 2, rx);
    for (i = 0; i < int'(r.nout); i++) begin
      host_bfm_i.shift(8'hFF, (r.mode != 0) ? 4 : 8, r.mode != 0, rx);
      check(35'(rx), 35'(r.expo[23 - 8 * i -: 8]));
    end
    host_bfm_i.end_frame();
  endtask
  // tail is left aligned; a count off the byte grid ends the frame mid-byte
  task automatic send(input logic [7:0] o, input int no, input logic [39:0] t, input int nt);
    logic [7:0] rx;
    int i;
    host_bfm_i.begin_frame();
    host_bfm_i.shift(o, no, 1'b0, rx);
    for (i = 0; i < nt; i += 8) host_bfm_i.shift(t[39 - i -: 8], (nt - i < 8) ? nt - i : 8, 1'b0, rx);
    repeat (4) @(negedge clk_in);
    oe_at_end = dev_so_oe_n;
    host_bfm_i.end_frame();
  endtask

  initial begin
    repeat (60000) @(posedge clk_in);
    failures++;
    wrap_up();
  end

  initial begin
    int k;
    logic [7:0] eop[6];
    req_kind_e ek[6];
    eop = '{OPC_SECTOR, OPC_BLOCK_A, OPC_BLOCK_B, OPC_CHIP_A, OPC_CHIP_B, OPC_STAT_WR};
    ek = '{REQ_SECTOR, REQ_BLOCK, REQ_BLOCK, REQ_CHIP, REQ_CHIP, REQ_STAT_WR};
    rows = '{mk(OPC_STAT_RD1, 0, 0, 0, 2, 24'hA0A000), mk(OPC_STAT_RD2, 0, 0, 0, 2, 24'h4C4C00),
      mk(OPC_READ, 3, 32'h0012FE, 0, 3, {pat(24'h12FE), pat(24'h12FF), pat(24'h1300)}),
      mk(OPC_FAST, 4, 32'h00A5FF00, 0, 2, {pat(24'hA5FF), pat(24'hA600), 8'h00}),
      mk(OPC_DUAL_OUT, 4, 32'h00003400, 1, 2, {pat(24'h34), pat(24'h35), 8'h00}),
      mk(OPC_DUAL_IO, 4, 32'h000C8100, 2, 2, {pat(24'hC81), pat(24'hC82), 8'h00}),
      mk(OPC_IDENT, 0, 0, 0, 3, {MAKER, PART}),
      mk(OPC_MAKER, 3, 32'h0, 0, 3, {MAKER, PART[7:0], MAKER}),
      mk(OPC_MAKER, 3, 32'h1, 0, 3, {PART[7:0], MAKER, PART[7:0]}),
      mk(OPC_WAKE, 3, 32'h0, 0, 3, {3{SIG}})};
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    check(35'({write_enable_latch, pd, req_valid, dev_so_oe_n, dev_si_oe_n, array_addr}), 35'h3000000);
    for (k = 0; k < 10; k++) run_row(rows[k]);
    send(OPC_LATCH_SET, 8, 0, 0);
    check(35'(write_enable_latch), 35'h1);
    run_row(mk(OPC_STAT_RD1, 0, 0, 0, 1, 24'hA20000));
    send(OPC_LATCH_CLR, 8, 0, 0);
    check(35'(write_enable_latch), 35'h0);
    send(OPC_LATCH_SET, 8, 0, 1);
    send(OPC_LATCH_SET, 7, 0, 0);
    check(35'(write_enable_latch), 35'h0);
    send(OPC_PROG, 8, 40'h0000101122, 40);
    check(35'(reqs.size()), 35'h0);
    send(OPC_LATCH_SET, 8, 0, 0);
    req_ready_in = 1'b0;
    send(OPC_PROG, 8, 40'h0000101122, 40);
    check(35'(req_valid), 35'h1);
    req_ready_in = 1'b1;
    repeat (8) @(negedge clk_in);
    check(35'(reqs.size()), 35'h3);
    check(reqs[0], {REQ_PROG_BYTE, 24'h10, 8'h11});
    check(reqs[1], {REQ_PROG_BYTE, 24'h10, 8'h22});
    check(35'(reqs[2].kind), 35'(REQ_PROG_GO));
    check(35'(write_enable_latch), 35'h0);
    send(OPC_LATCH_SET, 8, 0, 0);
    send(OPC_PROG, 8, 40'h0000203300, 33);
    check(35'(reqs[$].kind), 35'(REQ_PROG_DROP));
    for (k = 0; k < 6; k++) begin
      reqs.delete();
      send(OPC_LATCH_SET, 8, 0, 0);
      send(eop[k], 8, (k == 5) ? 40'h8C00000000 : 40'h0123450000, (k < 3) ? 24 : (k == 5) ? 8 : 0);
      check(35'(reqs.size()), 35'h1);
      check(35'(reqs[0].kind), 35'(ek[k]));
      if (k < 3) check(35'(reqs[0].addr), 35'h12345);
      if (k == 5) check(35'(reqs[0].data), 35'h8C);
      check(35'(write_enable_latch), 35'h0);
    end
    busy_in = 1'b1;
    send(OPC_LATCH_SET, 8, 0, 0);
    check(35'(write_enable_latch), 35'h0);
    run_row(mk(OPC_STAT_RD1, 0, 0, 0, 2, 24'hA1A100));
    send(OPC_READ, 8, 40'h0001000000, 32);
    check(35'(oe_at_end), 35'h1);
    busy_in = 1'b0;
    send(OPC_PDOWN, 8, 0, 0);
    check(35'(pd), 35'h1);
    send(OPC_STAT_RD1, 8, 0, 16);
    check(35'(oe_at_end), 35'h1);
    send(OPC_WAKE, 8, 0, 0);
    check(35'(pd), 35'h0);
    send(OPC_READ, 8, 40'h0000400000, 27);
    check(35'({oe_at_end, dev_so_oe_n}), 35'h1);
    run_row(mk(OPC_STAT_RD1, 0, 0, 0, 1, 24'hA00000));
    send(OPC_LATCH_SET, 8, 0, 0);
    rst_n_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check(35'(write_enable_latch), 35'h0);
    rst_n_in = 1'b1;
    wrap_up();
  end
endmodule
